// ---- hw/smcs_pkg.sv ----
// Package for the operating-mode control and status block.
// Assumes a 20 MHz core clock and byte-wide register accesses.
package smcs_pkg;

    // Core clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int HOST_RST_HOLD_US = 20;
    localparam int HOST_RST_HOLD_CYC = (HOST_RST_HOLD_US * (CLK_HZ / 1_000_000) > 0) ?
        HOST_RST_HOLD_US * (CLK_HZ / 1_000_000) : 1;
    localparam int RST_CNT_W = 10;
    // Cycles for the released reset line to cross the synchroniser
    localparam int PIN_SETTLE_CYC = 2;

    // Register addresses
    localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
    localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;

    // Mode control field
    localparam int MC_LSB = 0;
    localparam int MC_W = 3;
    localparam logic [2:0] MC_SLEEP = 3'h1;
    localparam logic [2:0] MC_STANDBY = 3'h4;
    localparam logic [2:0] MC_NORMAL = 3'h7;
    localparam logic [2:0] MC_RESET_VAL = 3'h4;

    // Main status fields
    localparam int OVERTEMP_WARNING_STATE_BIT = 6;
    localparam int NMS_BIT = 5;
    localparam int RSS_LSB = 0;
    localparam int RSS_W = 5;
    localparam logic NMS_RESET_VAL = 1'b1;

    // Watchdog mode codes
    localparam logic [2:0] WMC_WINDOW = 3'h4;

    // Reset cause codes
    localparam logic [4:0] RSS_POWER_ON = 5'h00;
    localparam logic [4:0] RSS_CAN_WAKE = 5'h01;
    localparam logic [4:0] RSS_PIN_WAKE = 5'h04;
    localparam logic [4:0] RSS_WD_SLEEP = 5'h0c;
    localparam logic [4:0] RSS_DIAG_WAKE = 5'h0d;
    localparam logic [4:0] RSS_WD_EARLY = 5'h0e;
    localparam logic [4:0] RSS_WD_OVF = 5'h0f;
    localparam logic [4:0] RSS_ILL_WMC = 5'h10;
    localparam logic [4:0] RSS_EXT_RST = 5'h11;
    localparam logic [4:0] RSS_OVERTEMP = 5'h12;
    localparam logic [4:0] RSS_V1_UV = 5'h13;
    localparam logic [4:0] RSS_ILL_SLEEP = 5'h14;
    localparam logic [4:0] RSS_FRAME_ERR = 5'h16;

    // Operating modes
    typedef enum logic [2:0] {
        SMCS_OFF,
        SMCS_FORCED_NORMAL,
        SMCS_STANDBY,
        SMCS_NORMAL,
        SMCS_SLEEP,
        SMCS_RESET,
        SMCS_OVERTEMP
    } smcs_mode_t;

    // Asynchronous sense inputs, bundled for synchronising
    typedef struct packed {
        logic power_ok;
        logic overtemp_act;
        logic overtemp_warn;
        logic v1_undervoltage;
        logic host_reset_pin;
        logic can_wake;
        logic pin_wake;
        logic diag_wake;
        logic frame_err_wake;
    } smcs_sense_t;

    localparam int SENSE_W = $bits(smcs_sense_t);

    // Watchdog event inputs from the on-chip watchdog
    typedef struct packed {
        logic overflow;
        logic too_early;
        logic fail_flag;
        logic mode_write;
    } smcs_wd_evt_t;

endpackage

// ---- hw/smcs_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a slow level; the first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module smcs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // Two stages, frozen with the clock enable
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule
`default_nettype wire

// ---- hw/smcs_mode_ctrl.sv ----
// Operating-mode sequencer with mode control and main status registers.
// Assumes an SPI decoder on the same clock presents byte register accesses.
//
// Behaviour
// - Leaving Reset goes to Forced Normal when forced_normal_cfg is 1.
// - Mode select codes: 001 Sleep, 100 Standby, 111 Normal.
// - Mode control at address 0x01; bits 2:0 writable, 7:3 read zero.
// - Status bit 6 follows the overtemperature warning level.
// - Status bit 5 is 1 from power-up until Normal first entered.
// - Cause 10001 external reset, 10010 overtemp exit, 10011 undervoltage.
// - Leaving Off sets reset cause to 00000.
// - Sleep wake causes: 00001 CAN, 00100 wake pin, 01101 diagnostic.
// - Watchdog causes: 01100 sleep overflow, 01110 too early, 01111 overflow.
// - Cause 10000 illegal watchdog mode change, 10100 rejected Sleep request.
// - Sleep exit on frame detect error records cause 10110.
// - Watchdog off except in Standby, Normal and Sleep.
// - Window watchdog operation only active in Normal mode.
// - Register access only in Forced Normal, Standby and Normal.
// - Sleep only if no wake pending and a wake source enabled.
// - Without forced normal, Reset exits to Standby after reset release.
`timescale 1ns/100ps
`default_nettype none
module smcs_mode_ctrl
    import smcs_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // Asynchronous analogue and pin senses
    input wire smcs_sense_t sense_in,
    // Watchdog events and settings, same clock
    input wire smcs_wd_evt_t wd_evt_in,
    input wire logic [2:0] watchdog_mode_select_in,
    // Configuration and wake qualifiers, same clock
    input wire logic forced_normal_cfg_in,
    input wire logic wake_pending_in,
    input wire logic wake_src_enabled_in,
    // Register access port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Mode and function enables
    output smcs_mode_t mode_out,
    output logic host_reset_out_n_out,
    output logic main_regulator_en_out,
    output logic spi_en_out,
    output logic watchdog_en_out,
    output logic watchdog_window_out
);

    smcs_sense_t sense;
    smcs_mode_t mode;
    smcs_mode_t next_mode;
    logic [2:0] operating_mode_select;
    logic normal_entered_flag;
    logic [4:0] reset_cause_code;
    logic [4:0] next_cause;
    logic cause_load;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic spi_ok;
    logic mc_write;
    logic [1:0] pin_settle;

    // True in modes where the host side is alive
    function automatic logic host_alive(input smcs_mode_t m);
        return (m == SMCS_FORCED_NORMAL) || (m == SMCS_STANDBY) || (m == SMCS_NORMAL);
    endfunction

    // Synchronise pin and analogue levels
    smcs_sync #(
        .WIDTH(SENSE_W)
    ) u_sync (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .async_in(sense_in),
        .sync_out(sense)
    );

    assign spi_ok = host_alive(mode);
    assign mc_write = reg_wr_in && spi_ok && (reg_addr_in == ADDR_MODE_CTRL);

    // Next mode and reset cause selection
    always_comb begin
        next_mode = mode;
        next_cause = reset_cause_code;
        cause_load = 1'b0;
        if (!sense.power_ok) begin
            next_mode = SMCS_OFF;
        end else begin
            case (mode)
                SMCS_OFF: begin
                    next_mode = SMCS_RESET;
                    next_cause = RSS_POWER_ON;
                    cause_load = 1'b1;
                end
                SMCS_RESET: begin
                    if (sense.overtemp_act) begin
                        next_mode = SMCS_OVERTEMP;
                    end else if (!sense.v1_undervoltage && rst_cnt == '0) begin
                        next_mode = forced_normal_cfg_in ? SMCS_FORCED_NORMAL : SMCS_STANDBY;
                    end
                end
                SMCS_OVERTEMP: begin
                    if (!sense.overtemp_act) begin
                        next_mode = SMCS_RESET;
                        next_cause = RSS_OVERTEMP;
                        cause_load = 1'b1;
                    end
                end
                SMCS_SLEEP: begin
                    cause_load = 1'b1;
                    next_mode = SMCS_RESET;
                    if (sense.can_wake) begin
                        next_cause = RSS_CAN_WAKE;
                    end else if (sense.pin_wake) begin
                        next_cause = RSS_PIN_WAKE;
                    end else if (sense.diag_wake) begin
                        next_cause = RSS_DIAG_WAKE;
                    end else if (sense.frame_err_wake) begin
                        next_cause = RSS_FRAME_ERR;
                    end else if (wd_evt_in.overflow) begin
                        next_cause = RSS_WD_SLEEP;
                    end else begin
                        next_mode = SMCS_SLEEP;
                        cause_load = 1'b0;
                    end
                end
                SMCS_FORCED_NORMAL, SMCS_STANDBY, SMCS_NORMAL: begin
                    cause_load = 1'b1;
                    next_mode = SMCS_RESET;
                    if (sense.overtemp_act) begin
                        next_mode = SMCS_OVERTEMP;
                        cause_load = 1'b0;
                    end else if (sense.v1_undervoltage) begin
                        next_cause = RSS_V1_UV;
                    end else if (!sense.host_reset_pin && pin_settle == '0) begin
                        next_cause = RSS_EXT_RST;
                    end else if (mode != SMCS_FORCED_NORMAL && wd_evt_in.too_early) begin
                        next_cause = RSS_WD_EARLY;
                    end else if (mode != SMCS_FORCED_NORMAL && wd_evt_in.overflow) begin
                        next_cause = RSS_WD_OVF;
                    end else if (mode == SMCS_NORMAL && wd_evt_in.mode_write) begin
                        next_cause = RSS_ILL_WMC;
                    end else begin
                        cause_load = 1'b0;
                        next_mode = mode;
                        if (mc_write && mode != SMCS_FORCED_NORMAL) begin
                            case (reg_wdata_in[MC_LSB +: MC_W])
                                MC_STANDBY: next_mode = SMCS_STANDBY;
                                MC_NORMAL: next_mode = SMCS_NORMAL;
                                MC_SLEEP: begin
                                    if (!wake_pending_in && wake_src_enabled_in) begin
                                        next_mode = SMCS_SLEEP;
                                    end else begin
                                        next_mode = SMCS_RESET;
                                        next_cause = RSS_ILL_SLEEP;
                                        cause_load = 1'b1;
                                    end
                                end
                                default: next_mode = mode;
                            endcase
                        end
                    end
                end
                default: next_mode = SMCS_OFF;
            endcase
        end
    end

    // Mode state
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode <= SMCS_OFF;
        end else if (ce_in) begin
            mode <= next_mode;
        end
    end

    // Reset hold timer, reloaded on every entry to Reset
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_cnt <= RST_CNT_W'(HOST_RST_HOLD_CYC);
        end else if (ce_in) begin
            if (mode != SMCS_RESET) begin
                rst_cnt <= RST_CNT_W'(HOST_RST_HOLD_CYC);
            end else if (rst_cnt != '0) begin
                rst_cnt <= rst_cnt - 1'b1;
            end
        end
    end

    // Masks the read-back line until our own release has reached the synchroniser output
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_settle <= 2'(PIN_SETTLE_CYC);
        end else if (ce_in) begin
            if (!host_alive(mode)) begin
                pin_settle <= 2'(PIN_SETTLE_CYC);
            end else if (pin_settle != '0) begin
                pin_settle <= pin_settle - 1'b1;
            end
        end
    end

    // Reset cause record
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reset_cause_code <= RSS_POWER_ON;
        end else if (ce_in && cause_load) begin
            reset_cause_code <= next_cause;
        end
    end

    // Normal-mode-entered flag, set again at power loss
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            normal_entered_flag <= NMS_RESET_VAL;
        end else if (ce_in) begin
            if (mode == SMCS_OFF) begin
                normal_entered_flag <= NMS_RESET_VAL;
            end else if (mode == SMCS_NORMAL) begin
                normal_entered_flag <= 1'b0;
            end
        end
    end

    // Mode select field storage
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            operating_mode_select <= MC_RESET_VAL;
        end else if (ce_in && mc_write) begin
            operating_mode_select <= reg_wdata_in[MC_LSB +: MC_W];
        end
    end

    // Register read data, reserved bits zero
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (ce_in && reg_rd_in) begin
            reg_rdata_out <= 8'h00;
            if (spi_ok && reg_addr_in == ADDR_MODE_CTRL) begin
                reg_rdata_out[MC_LSB +: MC_W] <= operating_mode_select;
            end else if (spi_ok && reg_addr_in == ADDR_MAIN_STATUS) begin
                reg_rdata_out[OVERTEMP_WARNING_STATE_BIT] <= sense.overtemp_warn;
                reg_rdata_out[NMS_BIT] <= normal_entered_flag;
                reg_rdata_out[RSS_LSB +: RSS_W] <= reset_cause_code;
            end
        end
    end

    // Function enables per mode
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_out <= SMCS_OFF;
            host_reset_out_n_out <= 1'b0;
            main_regulator_en_out <= 1'b0;
            spi_en_out <= 1'b0;
            watchdog_en_out <= 1'b0;
            watchdog_window_out <= 1'b0;
        end else if (ce_in) begin
            mode_out <= next_mode;
            host_reset_out_n_out <= host_alive(next_mode);
            main_regulator_en_out <= host_alive(next_mode) || next_mode == SMCS_RESET;
            spi_en_out <= host_alive(next_mode);
            watchdog_en_out <= (next_mode == SMCS_STANDBY) || (next_mode == SMCS_NORMAL) ||
                (next_mode == SMCS_SLEEP);
            watchdog_window_out <= (next_mode == SMCS_NORMAL) &&
                (watchdog_mode_select_in == WMC_WINDOW);
        end
    end

endmodule
`default_nettype wire

// ---- dv/smcs_mode_ctrl_asserts.sv ----
// Checker for the mode control block, bound to its top ports.
// Assumes one clock domain and the block's package.
`timescale 1ns/100ps
`default_nettype none
module smcs_mode_ctrl_chk
    import smcs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // Inputs watched
    input wire logic ce_in,
    input wire smcs_sense_t sense_in,
    input wire logic forced_normal_cfg_in,
    input wire logic wake_pending_in,
    input wire logic wake_src_enabled_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    // Outputs watched
    input wire logic [7:0] reg_rdata_out,
    input wire smcs_mode_t mode_out,
    input wire logic host_reset_out_n_out,
    input wire logic spi_en_out,
    input wire logic watchdog_en_out,
    input wire logic watchdog_window_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!arst_n_in);
    logic act;
    logic rd;
    // Active modes and an accepted read
    assign act = mode_out inside {SMCS_FORCED_NORMAL, SMCS_STANDBY, SMCS_NORMAL};
    assign rd = reg_rd_in && ce_in && act;
    sequence s_leave_reset;
        mode_out == SMCS_RESET ##1 mode_out inside {SMCS_FORCED_NORMAL, SMCS_STANDBY};
    endsequence
    sequence s_normal_read;
        mode_out == SMCS_NORMAL [*3] ##0 rd && reg_addr_in == ADDR_MAIN_STATUS;
    endsequence
    sequence s_warn_read;
        $stable(sense_in.overtemp_warn) [*5] ##0 rd && reg_addr_in == ADDR_MAIN_STATUS;
    endsequence
    property p_host_reset;
        host_reset_out_n_out == act;
    endproperty
    a_host_reset: assert property (p_host_reset) else $error("host reset level wrong");
    property p_spi;
        spi_en_out == act;
    endproperty
    a_spi: assert property (p_spi) else $error("register access enable wrong");
    property p_wd_off;
        mode_out inside {SMCS_OFF, SMCS_FORCED_NORMAL, SMCS_RESET, SMCS_OVERTEMP} |-> !watchdog_en_out;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog on in a forced-off mode");
    property p_window;
        watchdog_window_out |-> mode_out == SMCS_NORMAL;
    endproperty
    a_window: assert property (p_window) else $error("window operation outside normal");
    property p_sleep_rej;
        reg_wr_in && ce_in && mode_out inside {SMCS_STANDBY, SMCS_NORMAL} && reg_addr_in == ADDR_MODE_CTRL
            && reg_wdata_in[2:0] == MC_SLEEP && (wake_pending_in || !wake_src_enabled_in) |=> mode_out == SMCS_RESET;
    endproperty
    a_sleep_rej: assert property (p_sleep_rej) else $error("sleep with wake pending");
    property p_leave_reset;
        s_leave_reset |-> mode_out == (forced_normal_cfg_in ? SMCS_FORCED_NORMAL : SMCS_STANDBY);
    endproperty
    a_leave_reset: assert property (p_leave_reset) else $error("wrong mode after reset");
    property p_ctrl_read;
        rd && reg_addr_in == ADDR_MODE_CTRL |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("reserved bits not zero");
    property p_nms;
        s_normal_read |=> !reg_rdata_out[5];
    endproperty
    a_nms: assert property (p_nms) else $error("normal flag not cleared");
    property p_overtemp_warning_state;
        s_warn_read |=> reg_rdata_out[6] == $past(sense_in.overtemp_warn);
    endproperty
    a_overtemp_warning_state: assert property (p_overtemp_warning_state) else $error("warning bit wrong");
endmodule
`default_nettype wire

// ---- dv/smcs_host_model.sv ----
// Host side of the reset line: open drain with a pull-up.
// Assumes device and host may each pull the line low.
`timescale 1ns/100ps
`default_nettype none
module smcs_host_model (
    // Device drive and host pull
    input wire logic host_reset_n_in,
    input wire logic pull_low_in,
    // Level seen on the line
    output logic line_out
);
    // Pull-up wins unless a side pulls low
    assign line_out = host_reset_n_in & ~pull_low_in;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the mode control block.
// Assumes the host model on the reset line and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import smcs_pkg::*;
;
    logic clk;
    logic rst_n;
    logic [8:0] sv;
    logic [3:0] wd;
    logic fn, pend, pull, line, rds, wrs, hn, spi, wen, win, wse;
    logic [2:0] watchdog_mode_select;
    logic [6:0] ad;
    logic [7:0] wdt, rdt, d;
    smcs_mode_t mode;
    int fail_count, compares, cyc;
    logic [7:0] tab [13] = '{8'h11, 8'h13, 8'h12, 8'h0f, 8'h0e, 8'h10, 8'h14, 8'h01, 8'h04, 8'h0d, 8'h16, 8'h0c,
        8'h14};
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    smcs_host_model u_host (.host_reset_n_in(hn), .pull_low_in(pull), .line_out(line));
    smcs_mode_ctrl u_dut (.clock_in(clk), .arst_n_in(rst_n), .ce_in(1'b1),
        .sense_in(smcs_sense_t'({sv[8:5], line, sv[3:0]})), .wd_evt_in(smcs_wd_evt_t'(wd)),
        .watchdog_mode_select_in(watchdog_mode_select), .forced_normal_cfg_in(fn), .wake_pending_in(pend),
        .wake_src_enabled_in(wse), .reg_wr_in(wrs), .reg_rd_in(rds), .reg_addr_in(ad),
        .reg_wdata_in(wdt), .reg_rdata_out(rdt), .mode_out(mode), .host_reset_out_n_out(hn),
        .main_regulator_en_out(), .spi_en_out(spi), .watchdog_en_out(wen), .watchdog_window_out(win));
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp_mode(input smcs_mode_t e);
        compares++;
        if (mode !== e) begin
            fail_count++;
            $display("BAD mode exp %0d got %0d", e, mode);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        wrs = 1'b1;
        ad = a;
        wdt = v;
        @(posedge clk);
        #1;
        wrs = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge clk);
        #1;
        rds = 1'b1;
        ad = a;
        @(posedge clk);
        #1;
        rds = 1'b0;
        d = rdt;
    endtask
    task automatic wait_mode(input smcs_mode_t e);
        int n;
        n = 0;
        while (mode !== e && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp_mode(e);
    endtask
    // One reset source, then back to standby and read the cause
    task automatic evt(input int k, input logic [7:0] e);
        if (k >= 3 && k <= 5) begin
            wr(ADDR_MODE_CTRL, {5'h00, MC_NORMAL});
            wait_mode(SMCS_NORMAL);
        end
        if (k >= 6) begin
            pend = (k == 6);
            wse = (k != 12);
            wr(ADDR_MODE_CTRL, {5'h00, MC_SLEEP});
        end
        if (k >= 7 && k <= 11) begin
            wait_mode(SMCS_SLEEP);
            cmp("sleep spi", 8'h00, {7'h00, spi});
        end
        case (k)
            0: pull = 1'b1;
            1: sv[5] = 1'b1;
            2: sv[7] = 1'b1;
            3, 11: wd = 4'h8;
            4: wd = 4'h4;
            5: wd = 4'h1;
            6, 12: ;
            default: sv[10 - k] = 1'b1;
        endcase
        @(posedge clk);
        #1;
        wd = 4'h0;
        wait_mode(k == 2 ? SMCS_OVERTEMP : SMCS_RESET);
        repeat (4) @(posedge clk);
        #1;
        sv = 9'h100;
        pull = 1'b0;
        pend = 1'b0;
        wse = 1'b1;
        wait_mode(SMCS_STANDBY);
        rd(ADDR_MAIN_STATUS);
        cmp("cause", e, {3'h0, d[4:0]});
        $display("test event %0d done", k);
    endtask
    // Run-length guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            end_sim;
        end
    end
    initial begin
        rst_n = 1'b0;
        sv = 9'h100;
        wd = 4'h0;
        fn = 1'b0;
        pend = 1'b0;
        wse = 1'b1;
        watchdog_mode_select = WMC_WINDOW;
        pull = 1'b0;
        rds = 1'b0;
        wrs = 1'b0;
        ad = 7'h00;
        wdt = 8'h00;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        wait_mode(SMCS_STANDBY);
        rd(ADDR_MAIN_STATUS);
        cmp("status", 8'h20, d);
        rd(ADDR_MODE_CTRL);
        cmp("mode ctrl", 8'h04, d);
        rd(7'h05);
        cmp("unmapped", 8'h00, d);
        wr(ADDR_MODE_CTRL, 8'hff);
        wait_mode(SMCS_NORMAL);
        cmp("window", 8'h01, {7'h00, win});
        watchdog_mode_select = 3'h2;
        @(posedge clk);
        #1;
        cmp("window", 8'h00, {7'h00, win});
        watchdog_mode_select = WMC_WINDOW;
        rd(ADDR_MODE_CTRL);
        cmp("mode ctrl", 8'h07, d);
        sv[6] = 1'b1;
        repeat (6) @(posedge clk);
        rd(ADDR_MAIN_STATUS);
        cmp("status", 8'h40, d);
        sv[6] = 1'b0;
        wr(ADDR_MODE_CTRL, {5'h00, MC_STANDBY});
        wait_mode(SMCS_STANDBY);
        cmp("window", 8'h00, {7'h00, win});
        $display("test basic done");
        for (int k = 0; k < 13; k++) evt(k, tab[k]);
        fn = 1'b1;
        sv[8] = 1'b0;
        wait_mode(SMCS_OFF);
        sv[8] = 1'b1;
        wait_mode(SMCS_FORCED_NORMAL);
        cmp("wd enable", 8'h00, {7'h00, wen});
        rd(ADDR_MAIN_STATUS);
        cmp("status", 8'h20, d);
        $display("test forced normal done");
        end_sim;
    end
endmodule
bind smcs_mode_ctrl smcs_mode_ctrl_chk u_chk (.clock_in(clock_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
    .sense_in(sense_in), .forced_normal_cfg_in(forced_normal_cfg_in), .wake_pending_in(wake_pending_in),
    .wake_src_enabled_in(wake_src_enabled_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .mode_out(mode_out), .host_reset_out_n_out(host_reset_out_n_out),
    .spi_en_out(spi_en_out), .watchdog_en_out(watchdog_en_out), .watchdog_window_out(watchdog_window_out));
`default_nettype wire
